// file: fifo_flags_pkg.sv
// Constants shared by the multi-queue flag block
`default_nettype none
package fifo_flags_pkg;
  // Queue organisation
  localparam int NQ        = 4;   // Queues in four-queue mode
  localparam int QW        = 10;  // Narrow word width
  localparam int WW        = 20;  // Wide word width, dual mode
  localparam int BUS_W     = 40;  // Write and read data bus width
  localparam int DEPTH_DEF = 16;  // Default memory words per queue
  localparam int OFF_W     = 8;   // Almost-empty offset width
  localparam logic [7:0] OFF_DEF = 8'h07; // Offset after reset
  // Register map
  localparam int ADR_W = 4;
  localparam logic [3:0] A_CTRL = 4'h0; // Control, read/write
  localparam logic [3:0] A_STAT = 4'h4; // Status, read only
  localparam int CTRL_HOLD = 0;         // Block enabled reads; fall-through still loads the shown word
  localparam int ST_EMPTY  = 0;         // Empty or output-ready pins
  localparam int ST_FULL   = 4;         // Full or input-ready pins
  localparam int ST_AE     = 8;         // Almost-empty pins
  localparam int ST_FALL   = 12;        // Fall-through mode latched
  localparam int ST_QUAD   = 13;        // Four-queue mode latched
  localparam int ST_W20    = 14;        // Twenty-bit words latched
  // Positions inside the synchronised pin vector
  localparam int P_WCLK = 0;
  localparam int P_RCLK = 4;
  localparam int P_WEN  = 8;
  localparam int P_REN  = 12;
  localparam int P_SI   = 16;
  localparam int P_SRE  = 17;
  localparam int P_SLE  = 18;
  localparam int P_SCLK = 19;
  localparam int P_D    = 20;
  localparam int P_TSEL = 60;
  localparam int P_QUAD = 61;
  localparam int P_W20  = 62;
  localparam int P_W    = 63;
endpackage
`default_nettype wire

// file: fifo_status_flags.sv
// Multi-queue store with status flags, serial offset port and register slave
`timescale 1ns/1ns
`default_nettype none
module fifo_status_flags
  import fifo_flags_pkg::*;
#(
  parameter int DEPTH = fifo_flags_pkg::DEPTH_DEF, // Power of two
  parameter int OW    = fifo_flags_pkg::OFF_W,
  parameter logic [fifo_flags_pkg::OFF_W-1:0] ODEF = fifo_flags_pkg::OFF_DEF
)
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [fifo_flags_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // Straps, caught at reset
  input  wire logic                       fallthrough_select_serial_in_i,
  input  wire logic                       flag_timing_select_i,
  input  wire logic                       quad_mode_i,
  input  wire logic                       bus20_i,
  // Serial offset port
  input  wire logic                       sclk_i,
  input  wire logic                       serial_load_enable_n_i,
  input  wire logic                       serial_readback_enable_n_i,
  output logic                            serial_readback_out_o,
  // Write ports
  input  wire logic [fifo_flags_pkg::NQ-1:0]    wclk_i,
  input  wire logic [fifo_flags_pkg::NQ-1:0]    wen_n_i,
  input  wire logic [fifo_flags_pkg::BUS_W-1:0] d_i,
  // Read ports
  input  wire logic [fifo_flags_pkg::NQ-1:0]    rclk_i,
  input  wire logic [fifo_flags_pkg::NQ-1:0]    ren_n_i,
  output logic      [fifo_flags_pkg::BUS_W-1:0] q_o,
  // Flag pins
  output logic      [fifo_flags_pkg::NQ-1:0]    queue_empty_n_o,
  output logic      [fifo_flags_pkg::NQ-1:0]    queue_full_n_o,
  output logic      [fifo_flags_pkg::NQ-1:0]    almost_empty_n_o
);
  import fifo_flags_pkg::*;

  localparam int AW  = $clog2(DEPTH); // Pointer width
  localparam int TOT = NQ * OW;       // Offset chain length

  // Pin synchroniser stages
  wire  [P_W-1:0] pin_w;    // All outside inputs except clock, reset and Wishbone in one vector
  logic [P_W-1:0] s1_r;     // First stage, read by s2_r only
  logic [P_W-1:0] s2_r;     // Safe level
  logic [P_W-1:0] s3_r;     // Previous level for edge finding
  // Latched modes
  logic           ft_r;     // Fall-through flag personality
  logic           tsel_r;   // Synchronous almost-empty timing
  logic           quad_r;   // Four-queue organisation
  logic           w20_r;    // Twenty-bit words in dual mode
  // Serial offset state
  logic [TOT-1:0] chain_r;  // Offsets, queue 0 at the top
  logic [TOT-1:0] scan_r;   // Scan-out copy
  // Register slave state
  logic           hold_r;   // Software read block
  logic           ack_r;
  logic [31:0]    dat_r;
  // Per-queue views
  logic [WW-1:0]  out_w [NQ];
  logic [AW:0]    cnt_w [NQ];
  wire  [NQ-1:0]  load_w;
  wire  [NQ-1:0]  empty_w;
  wire  [NQ-1:0]  full_w;
  wire  [NQ-1:0]  ae_w;
  wire  [BUS_W-1:0] q_quad;
  wire  [31:0]    stat_w;
  wire  [31:0]    rd_mux;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Gather outside pins into one synchroniser vector
  assign pin_w = {bus20_i, quad_mode_i, flag_timing_select_i, d_i, sclk_i,
                  serial_load_enable_n_i, serial_readback_enable_n_i,
                  fallthrough_select_serial_in_i, ren_n_i, wen_n_i, rclk_i, wclk_i};

  // Two-stage synchroniser plus edge history, no reset so straps stay live
  always_ff @(posedge clk_i)
  begin
    s1_r <= pin_w;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // Edges and levels seen on the system clock
  wire [NQ-1:0] wclk_rise = s2_r[P_WCLK +: NQ] & ~s3_r[P_WCLK +: NQ];
  wire [NQ-1:0] rclk_rise = s2_r[P_RCLK +: NQ] & ~s3_r[P_RCLK +: NQ];
  wire [NQ-1:0] wen_s     = s2_r[P_WEN +: NQ];
  wire [NQ-1:0] ren_s     = s2_r[P_REN +: NQ];
  wire [BUS_W-1:0] d_s    = s2_r[P_D +: BUS_W];
  wire sclk_rise = s2_r[P_SCLK] & ~s3_r[P_SCLK];
  wire si_s      = s2_r[P_SI];
  wire sle_s     = s2_r[P_SLE];
  wire sre_s     = s2_r[P_SRE];
  wire sre_fall  = ~s2_r[P_SRE] & s3_r[P_SRE];

  // Straps are caught while reset is held, so it must last three edges
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ft_r   <= s2_r[P_SI];
      tsel_r <= s2_r[P_TSEL];
      quad_r <= s2_r[P_QUAD];
      w20_r  <= s2_r[P_W20];
    end
  end

  // Offset chain: shifts only while the load enable is low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chain_r <= {NQ{ODEF}};
    else if (sclk_rise && !sle_s)
      chain_r <= {chain_r[TOT-2:0], si_s};
  end

  // Scan-out register: copy on enable fall, then shift MSB first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      scan_r <= '0;
    else if (sre_fall)
      scan_r <= chain_r;
    else if (sclk_rise && !sre_s)
      scan_r <= {scan_r[TOT-2:0], 1'b0};
  end
  assign serial_readback_out_o = scan_r[TOT-1];

  // One slice of queue logic per queue; nothing crosses between slices
  for (genvar i = 0; i < NQ; i++)
  begin : g_q
    localparam int LO10 = i * QW;
    localparam int LO20 = (i / 2) * WW;
    logic [AW-1:0] wp_r;           // Write pointer
    logic [AW-1:0] rp_r;           // Read pointer
    logic [AW:0]   cnt_r;          // Words in memory
    logic [WW-1:0] mem_r [DEPTH];  // Flip-flop storage
    logic [WW-1:0] out_r;          // Output register
    logic          e1_r;           // Empty path, first stage
    logic          e2_r;           // Empty path, second stage
    logic          ov_r;           // Output register holds a word
    logic          f1_r;           // Full path, first stage
    logic          f2_r;           // Full path, second stage
    logic          ae_r;           // Almost-empty pin state
    // Word lane for this queue under the latched organisation
    wire [WW-1:0] win = w20_r ? d_s[LO20 +: WW] : {{(WW-QW){1'b0}}, d_s[LO10 +: QW]};
    // Dual mode leaves queues 1 and 3 idle
    wire act = quad_r || (i % 2 == 0);
    // Occupancy counts the shown word in fall-through mode
    wire [AW+1:0] occ = {1'b0, cnt_r} + (AW+2)'(ft_r & ov_r);
    wire [AW+1:0] cap = (AW+2)'(DEPTH) + (AW+2)'(ft_r);
    wire full_c = occ >= cap;
    wire fill   = (occ + (AW+2)'(1)) >= cap;
    wire rd_ok  = rclk_rise[i] & ~ren_s[i] & ~hold_r & act;
    wire wr     = wclk_rise[i] & ~wen_s[i] & act & ~full_c;
    wire pop_sd = ~ft_r & rd_ok & e2_r & (|cnt_r);
    // A read of the shown word with nothing behind it empties the register
    wire take   = ft_r & rd_ok & ov_r;
    // Third read edge after a write moves the word to the outputs
    wire load   = ft_r & rclk_rise[i] & e2_r & (|cnt_r) & (~ov_r | take);
    wire pop    = pop_sd | load;
    wire last   = pop & ~wr & (cnt_r == (AW+1)'(1));
    wire [OW-1:0] n_off = chain_r[TOT-1-i*OW -: OW];
    wire ae_c   = ft_r ? (int'(occ) < int'(n_off)) : (int'(cnt_r) <= int'(n_off));

    // Memory writes; no reset needed on data
    always_ff @(posedge clk_i)
    begin
      if (wr)
        mem_r[wp_r] <= win;
    end

    // Pointers and word count
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        wp_r  <= '0;
        rp_r  <= '0;
        cnt_r <= '0;
      end
      else
      begin
        if (wr)
          wp_r <= wp_r + (AW)'(1);
        if (pop)
          rp_r <= rp_r + (AW)'(1);
        cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(pop);
      end
    end

    // Output register; old data stays when the queue runs dry
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        out_r <= '0;
        ov_r  <= 1'b0;
      end
      else
      begin
        if (pop)
          out_r <= mem_r[rp_r];
        if (load)
          ov_r <= 1'b1;
        else if (take)
          ov_r <= 1'b0;
      end
    end

    // Empty path on read edges; last read drops it at once to stop overreads
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        e1_r <= 1'b0;
        e2_r <= 1'b0;
      end
      else if (last)
      begin
        e1_r <= 1'b0;
        e2_r <= 1'b0;
      end
      else if (rclk_rise[i])
      begin
        e1_r <= |cnt_r;
        e2_r <= e1_r;
      end
    end

    // Full path on write edges; a filling write asserts at once
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        f1_r <= 1'b0;
        f2_r <= 1'b0;
      end
      else if (wclk_rise[i])
      begin
        if (wr && fill)
        begin
          f1_r <= 1'b1;
          f2_r <= 1'b1;
        end
        else
        begin
          f1_r <= full_c;
          f2_r <= f1_r;
        end
      end
    end

    // Almost-empty: read edge updates, or split assert and release edges
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        ae_r <= 1'b0;
      else
      begin
        if (rclk_rise[i] && (tsel_r || ae_c))
          ae_r <= ~ae_c;
        if (wclk_rise[i] && !tsel_r && !ae_c)
          ae_r <= 1'b1;
      end
    end

    // Pin personality follows the latched mode
    assign empty_w[i] = ft_r ? ~ov_r : e2_r;
    assign full_w[i]  = ft_r ? f2_r : ~f2_r;
    assign ae_w[i]    = ae_r;
    assign load_w[i]  = load;
    assign out_w[i]   = out_r;
    assign cnt_w[i]   = cnt_r;
    assign q_quad[LO10 +: QW] = out_r[QW-1:0];
  end

  // Read bus lanes under the latched organisation
  assign q_o = quad_r ? q_quad :
               w20_r  ? {out_w[2], out_w[0]} :
               {{QW{1'b0}}, out_w[2][QW-1:0], {QW{1'b0}}, out_w[0][QW-1:0]};
  assign queue_empty_n_o  = empty_w;
  assign queue_full_n_o   = full_w;
  assign almost_empty_n_o = ae_w;

  // Status word
  assign stat_w[ST_EMPTY +: NQ] = empty_w;
  assign stat_w[ST_FULL +: NQ]  = full_w;
  assign stat_w[ST_AE +: NQ]    = ae_w;
  assign stat_w[ST_FALL]        = ft_r;
  assign stat_w[ST_QUAD]        = quad_r;
  assign stat_w[ST_W20]         = w20_r;
  assign stat_w[31:ST_W20+1]    = '0;

  // Address decode; unmapped reads return zero
  wire req      = wb_cyc_i & wb_stb_i & ~ack_r;
  wire hit_ctrl = wb_adr_i == A_CTRL;
  wire hit_stat = wb_adr_i == A_STAT;
  assign rd_mux = hit_ctrl ? {31'h0, hold_r} : hit_stat ? stat_w : 32'h0;

  // Register slave: answers one edge after the request, every address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r  <= 1'b0;
      dat_r  <= 32'h0;
      hold_r <= 1'b0;
    end
    else
    begin
      ack_r <= req;
      if (req)
        dat_r <= rd_mux;
      if (req && wb_we_i && wb_sel_i[0] && hit_ctrl)
        hold_r <= wb_dat_i[CTRL_HOLD];
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Checks on the serial port
  a_load_shift:
    assert property (sclk_rise && !sle_s |=> chain_r[0] == $past(si_s))
    else $error("serial bit not taken into chain");
  a_load_hold:
    assert property (sle_s |=> $stable(chain_r))
    else $error("offsets changed while load disabled");
  a_scan_copy:
    assert property (sre_fall |=> scan_r == $past(chain_r))
    else $error("scan register missed offset copy");
  a_scan_shift:
    assert property (sclk_rise && !sre_s && !sre_fall |=> scan_r == ($past(scan_r) << 1))
    else $error("scan register did not shift");
  a_scan_idle:
    assert property (sre_s |=> $stable(scan_r))
    else $error("scan register moved while readback off");
  // Checks on the data lanes
  a_quad_lane:
    assert property (quad_r |-> q_o[19:10] == out_w[1][QW-1:0] && q_o[39:30] == out_w[3][QW-1:0])
    else $error("four-queue lane wrong");
  a_dual_lane:
    assert property (!quad_r && !w20_r |-> q_o[29:20] == out_w[2][QW-1:0] && q_o[19:10] == 10'h0)
    else $error("ten-bit dual lane wrong");
  // Checks on queue flags; the bench fills queue 1 in standard mode
  a_empty_low:
    assert property (!ft_r && cnt_w[0] == '0 |-> !queue_empty_n_o[0])
    else $error("empty flag high with no words");
  a_ready_shown:
    assert property (ft_r && load_w[0] |=> !queue_empty_n_o[0] && out_w[0] == $past(g_q[0].mem_r[g_q[0].rp_r]))
    else $error("output-ready not low with shown word");
  a_full_fill:
    assert property (!ft_r && g_q[1].wr && g_q[1].fill |=> !queue_full_n_o[1])
    else $error("full flag not low after filling write");
  a_ae_sync:
    assert property (tsel_r && rclk_rise[0] |=> almost_empty_n_o[0] == !$past(g_q[0].ae_c))
    else $error("almost-empty not updated on read edge");
endmodule
`default_nettype wire

// file: fifo_host_model.sv
// Host controller model driving queue pins and the serial offset port
`timescale 1ns/1ns
`default_nettype none
module fifo_host_model
  import fifo_flags_pkg::*;
(
  // System clock
  input  wire logic                             clk_i,
  // Queue pins
  output logic      [fifo_flags_pkg::NQ-1:0]    wclk_o,
  output logic      [fifo_flags_pkg::NQ-1:0]    wen_n_o,
  output logic      [fifo_flags_pkg::BUS_W-1:0] d_o,
  output logic      [fifo_flags_pkg::NQ-1:0]    rclk_o,
  output logic      [fifo_flags_pkg::NQ-1:0]    ren_n_o,
  // Serial offset port
  output logic                                  sclk_o,
  output logic                                  sle_n_o,
  output logic                                  sre_n_o,
  output logic                                  si_o,
  input  wire logic                             sdo_i
);
  // Clocks stand low between frames, enables idle high
  initial
  begin
    wclk_o = '0;
    rclk_o = '0;
    wen_n_o = '1;
    ren_n_o = '1;
    d_o = '0;
    sclk_o = 1'b0;
    sle_n_o = 1'b1;
    sre_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Idle for n system clocks
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Strap level, also the serial data line
  task automatic set_si(input logic b);
    si_o <= b;
  endtask
  // One 800 ns serial clock period, four system clocks each half
  task automatic spulse();
    sclk_o <= 1'b1;
    waitc(4);
    sclk_o <= 1'b0;
    waitc(4);
  endtask
  // One write clock period; data valid from one system clock before the rise until the clock falls
  task automatic wr(input int q, input logic [39:0] v, input logic en);
    d_o <= v;
    wen_n_o[q] <= ~en;
    waitc(1);
    wclk_o[q] <= 1'b1;
    waitc(4);
    wclk_o[q] <= 1'b0;
    wen_n_o[q] <= 1'b1;
    d_o <= ~v; // Released bus shows junk, not the old word
    waitc(3);
  endtask
  // One read clock period with optional read
  task automatic rd(input int q, input logic en);
    ren_n_o[q] <= ~en;
    waitc(1);
    rclk_o[q] <= 1'b1;
    waitc(4);
    rclk_o[q] <= 1'b0;
    ren_n_o[q] <= 1'b1;
    waitc(3);
  endtask
  // Load all offsets, queue 0 MSB first, enable held low throughout
  task automatic load(input logic [31:0] v);
    sle_n_o <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      si_o <= v[i];
      waitc(2);
      spulse();
    end
    sle_n_o <= 1'b1;
    si_o <= ~v[0];
    waitc(2);
  endtask
  // Read back all offsets, enable held low for every bit
  task automatic readback(output logic [31:0] v);
    sre_n_o <= 1'b0;
    waitc(8);
    for (int i = 0; i < 32; i++)
    begin
      v = {v[30:0], sdo_i};
      spulse();
    end
    sre_n_o <= 1'b1;
    waitc(8);
  endtask
endmodule
`default_nettype wire

// file: fifo_status_flags_serial_offsets_bench.sv
// Self-checking bench for the multi-queue flag block
`timescale 1ns/1ns
`default_nettype none
module fifo_status_flags_serial_offsets_bench;
  import fifo_flags_pkg::*;
  logic        clk;              // 10 MHz system clock
  logic        rst;              // Synchronous reset
  logic        cyc;              // Wishbone request
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        tsel;             // Straps
  logic        quad;
  logic        w20;
  logic        sclk;             // Serial port
  logic        sle_n;
  logic        sre_n;
  logic        si;
  logic        serial_readback_out;
  logic [3:0]  wclk;             // Queue pins
  logic [3:0]  wen_n;
  logic [3:0]  rclk;
  logic [3:0]  ren_n;
  logic [39:0] d;
  logic [39:0] q_data;
  logic [3:0]  empty_n;          // Flag pins
  logic [3:0]  full_n;
  logic [3:0]  ae_n;
  logic [31:0] r;                // Scratch read value
  int          mismatches;
  int          n_checks;

  // Small depth keeps fill scenarios short
  fifo_status_flags #(.DEPTH(4)) fifo_status_flags_inst (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fallthrough_select_serial_in_i(si), .flag_timing_select_i(tsel),
    .quad_mode_i(quad), .bus20_i(w20), .sclk_i(sclk),
    .serial_load_enable_n_i(sle_n), .serial_readback_enable_n_i(sre_n),
    .serial_readback_out_o(serial_readback_out), .wclk_i(wclk), .wen_n_i(wen_n), .d_i(d),
    .rclk_i(rclk), .ren_n_i(ren_n), .q_o(q_data), .queue_empty_n_o(empty_n),
    .queue_full_n_o(full_n), .almost_empty_n_o(ae_n));

  // Far-side host
  fifo_host_model fifo_host_model_inst (
    .clk_i(clk), .wclk_o(wclk), .wen_n_o(wen_n), .d_o(d), .rclk_o(rclk),
    .ren_n_o(ren_n), .sclk_o(sclk), .sle_n_o(sle_n), .sre_n_o(sre_n),
    .si_o(si), .sdo_i(serial_readback_out));

  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string nm, input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset held 20 cycles with straps stable
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Classic Wishbone cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= wd;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    mismatches = 0;
    n_checks = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h0;
    tsel = 1'b1;
    quad = 1'b1;
    w20 = 1'b0;
    @(posedge clk);
    do_reset();
    check("empty_rst", 40'(empty_n), 40'h0);
    check("full_rst", 40'(full_n), 40'hf);
    wb(1'b0, A_STAT, 32'h0, r);
    check("status", 40'(r), 40'h20f0);
    wb(1'b1, A_CTRL, 32'h1, r);
    wb(1'b0, A_CTRL, 32'h0, r);
    check("ctrl", 40'(r), 40'h1);
    wb(1'b1, A_CTRL, 32'h0, r);
    wb(1'b0, 4'h8, 32'h0, r);
    check("unmapped", 40'(r), 40'h0);
    // First word into queue 0, flag after second read edge
    fifo_host_model_inst.wr(0, 40'h2a5, 1'b1);
    fifo_host_model_inst.rd(0, 1'b0);
    check("empty_1st", 40'(empty_n), 40'h0);
    fifo_host_model_inst.rd(0, 1'b0);
    check("empty_2nd", 40'(empty_n), 40'h1);
    fifo_host_model_inst.rd(0, 1'b1);
    check("q0_lane", q_data, 40'h2a5);
    check("empty_last", 40'(empty_n), 40'h0);
    // Queue 3 lane, queue 0 word must stay put
    fifo_host_model_inst.wr(3, {10'h1c3, 30'h0}, 1'b1);
    fifo_host_model_inst.rd(3, 1'b0);
    fifo_host_model_inst.rd(3, 1'b0);
    fifo_host_model_inst.rd(3, 1'b1);
    check("q3_lane", q_data, {10'h1c3, 20'h0, 10'h2a5});
    // Fill queue 1, then free one place
    for (int i = 1; i <= 4; i++)
      fifo_host_model_inst.wr(1, {20'h0, 10'(i), 10'h0}, 1'b1);
    check("full_q1", 40'(full_n), 40'hd);
    fifo_host_model_inst.rd(1, 1'b0);
    fifo_host_model_inst.rd(1, 1'b0);
    fifo_host_model_inst.rd(1, 1'b1);
    check("q1_lane", q_data, {10'h1c3, 10'h0, 10'h1, 10'h2a5});
    fifo_host_model_inst.wr(1, 40'h0, 1'b0);
    check("full_hold", 40'(full_n), 40'hd);
    fifo_host_model_inst.wr(1, 40'h0, 1'b0);
    check("full_free", 40'(full_n), 40'hf);
    // Offsets in, read back twice around ignored clocks
    fifo_host_model_inst.load(32'h050200ff);
    fifo_host_model_inst.readback(r);
    check("offsets", 40'(r), 40'h050200ff);
    fifo_host_model_inst.set_si(1'b1);
    repeat (3) fifo_host_model_inst.spulse();
    fifo_host_model_inst.readback(r);
    check("offsets_kept", 40'(r), 40'h050200ff);
    // Queue 1 holds 3 words against offset 2
    fifo_host_model_inst.rd(1, 1'b0);
    fifo_host_model_inst.rd(1, 1'b0);
    check("ae_above", 40'(ae_n), 40'h2);
    fifo_host_model_inst.rd(1, 1'b1);
    fifo_host_model_inst.rd(1, 1'b0);
    check("ae_at_n", 40'(ae_n), 40'h0);
    // Fall-through personality, dual 20-bit, split-clock almost-empty
    fifo_host_model_inst.set_si(1'b1);
    quad <= 1'b0;
    w20 <= 1'b1;
    tsel <= 1'b0;
    do_reset();
    check("ready_rst", 40'(empty_n), 40'hf);
    check("inrdy_rst", 40'(full_n), 40'h0);
    fifo_host_model_inst.wr(0, 40'hab5c3, 1'b1);
    fifo_host_model_inst.rd(0, 1'b0);
    fifo_host_model_inst.rd(0, 1'b0);
    check("ready_2nd", 40'(empty_n), 40'hf);
    fifo_host_model_inst.rd(0, 1'b0);
    check("ready_3rd", 40'(empty_n), 40'he);
    check("q0_wide", q_data, 40'hab5c3);
    fifo_host_model_inst.rd(0, 1'b1);
    check("ready_gone", 40'(empty_n), 40'hf);
    check("q0_kept", q_data, 40'hab5c3);
    // Queue 2 takes one word beyond the memory depth
    fifo_host_model_inst.wr(2, {20'h1, 20'h0}, 1'b1);
    repeat (3) fifo_host_model_inst.rd(2, 1'b0);
    for (int i = 2; i <= 4; i++)
      fifo_host_model_inst.wr(2, {20'(i), 20'h0}, 1'b1);
    check("inrdy_room", 40'(full_n), 40'h0);
    fifo_host_model_inst.wr(2, {20'h5, 20'h0}, 1'b1);
    check("inrdy_full", 40'(full_n), 40'h4);
    // Queue 2 offset 2 against 5 held words: read edge keeps it low
    fifo_host_model_inst.load(32'h07070207);
    fifo_host_model_inst.rd(2, 1'b0);
    check("ae_split_rd", 40'(ae_n), 40'h0);
    fifo_host_model_inst.wr(2, 40'h0, 1'b0);
    check("ae_split_wr", 40'(ae_n), 40'h4);
    // Standard personality, dual 10-bit: queue 2 on bits 29:20
    fifo_host_model_inst.set_si(1'b0);
    w20 <= 1'b0;
    do_reset();
    fifo_host_model_inst.wr(2, {10'h0, 10'h155, 20'h0}, 1'b1);
    fifo_host_model_inst.rd(2, 1'b0);
    fifo_host_model_inst.rd(2, 1'b0);
    fifo_host_model_inst.rd(2, 1'b1);
    check("q2_narrow", q_data, {10'h0, 10'h155, 20'h0});
    end_of_test();
  end
endmodule
`default_nettype wire
